// File: hw/dssr_status_regs.sv
// Device status registers, manual fault recovery trigger and write checksum.
// Assumes the serial control decoder presents one-cycle writes and addresses on clk;
// analog status levels arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`include "dssr_defines.svh"
`default_nettype none

// Operation
// - Bit 7 shows channel one powered
// - Bit 6 shows channel two powered
// - Mode field: reset 4, 4/6/7 by state
// - Bit 4 shows boost converter powered
// - Bit 3 shows mic bias powered
// - Bit 2: any channel input-fault shutdown
// - Bit 1: all channels bias-fault shutdown
// - Writing 1 triggers recovery, self-clears
// - Checksum reads back, write overwrites it
// - Writes elsewhere, any page, update checksum
// - Reserved status bits read zero
// - Offset zero selects the active page
module dssr_status_regs
	import dssr_pkg::*;
(
	input wire logic clk, // 25 MHz register clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic reg_wr, // One-cycle write strobe
	input wire logic [7:0] reg_addr, // Offset within current page
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic chan_one_powered, // Analog: channel one up
	input wire logic chan_two_powered, // Analog: channel two up
	input wire logic device_active, // Analog: device out of sleep
	input wire logic boost_powered, // Analog: boost up
	input wire logic mic_bias_powered, // Analog: bias supply up
	input wire logic [1:0] chan_input_fault_pd, // Per channel: off by input fault
	input wire logic [1:0] chan_bias_fault_pd, // Per channel: off by bias fault
	output logic [7:0] reg_rdata, // Read data for last cycle's address
	output logic [7:0] page_sel, // Current page
	output logic manual_recovery_trigger // One-cycle recovery request
);

	// ==========================================================
	// Checksum step
	// ==========================================================
	// Rotate-left then add; swapping this body changes the block and its checks, but not the bench's own checksum model
	function automatic dssr_byte_t cksum_step(input dssr_byte_t acc, input dssr_byte_t data);
		cksum_step = {acc[6:0], acc[7]} + data;
	endfunction : cksum_step

	// ==========================================================
	// State
	// ==========================================================
	// Sync bits: 0 ch1, 1 ch2, 2 active, 3 boost, 4 bias, 6:5 input fault, 8:7 bias fault
	logic [`DSSR_SYNC_W-1:0] sync1_ff; // First synchroniser stage, read only by sync2
	logic [`DSSR_SYNC_W-1:0] sync2_ff; // Second synchroniser stage
	logic [`DSSR_SYNC_W-1:0] nxt_sync1;
	logic [`DSSR_SYNC_W-1:0] nxt_sync2;
	logic [7:0] chan_pwr_ff; // First status register image
	logic [7:0] nxt_chan_pwr;
	logic [7:0] dev_state_ff; // Second status register image
	logic [7:0] nxt_dev_state;
	logic [7:0] cksum_ff; // Running write checksum
	logic [7:0] nxt_cksum;
	logic [7:0] page_ff; // Page select
	logic [7:0] nxt_page;
	logic [7:0] rdata_ff; // Registered read data
	logic [7:0] nxt_rdata;
	logic recov_ff; // Recovery request pulse
	logic nxt_recov;
	logic on_status_page; // Current page holds these registers
	dssr_mode_t mode_now; // Mode from synchronised levels

	assign on_status_page = (page_ff == `DSSR_PAGE_STATUS);

	// ==========================================================
	// Next-value logic
	// ==========================================================
	always_comb begin
		// Pins are asynchronous to clk, so two flops before use
		nxt_sync1 = {chan_bias_fault_pd, chan_input_fault_pd, mic_bias_powered, boost_powered,
			device_active, chan_two_powered, chan_one_powered};
		// Status reads lag the pins by the two sync stages, the image flop and the read data flop
		nxt_sync2 = sync1_ff;

		if (!sync2_ff[2]) begin
			mode_now = DSSR_MODE_SLEEP;
		end else if (sync2_ff[0] || sync2_ff[1]) begin
			mode_now = DSSR_MODE_RUN;
		end else begin
			mode_now = DSSR_MODE_IDLE;
		end

		nxt_chan_pwr = `DSSR_RST_ZERO;
		nxt_chan_pwr[`DSSR_BIT_CH1_UP] = sync2_ff[0];
		nxt_chan_pwr[`DSSR_BIT_CH2_UP] = sync2_ff[1];

		// every status bit resampled each cycle, never latched
		nxt_dev_state = `DSSR_RST_ZERO;
		nxt_dev_state[`DSSR_FLD_MODE_HI:`DSSR_FLD_MODE_LO] = mode_now;
		nxt_dev_state[`DSSR_BIT_BOOST] = sync2_ff[3];
		nxt_dev_state[`DSSR_BIT_BIAS] = sync2_ff[4];
		nxt_dev_state[`DSSR_BIT_IN_FLT] = |sync2_ff[6:5];
		nxt_dev_state[`DSSR_BIT_BIAS_FLT] = &sync2_ff[8:7];
		// recovery bit reads set only during its pulse
		nxt_dev_state[`DSSR_BIT_RECOVER] = 1'b0;

		// a written one fires one pulse; zero does nothing
		// Host must park the fault response setup around this pulse; not enforced here
		nxt_recov = reg_wr && on_status_page && (reg_addr == `DSSR_ADDR_DEV_STATE)
			&& reg_wdata[`DSSR_BIT_RECOVER];

		// page select lives at offset zero on every page
		nxt_page = page_ff;
		if (reg_wr && (reg_addr == `DSSR_ADDR_PAGE_SEL)) begin
			nxt_page = reg_wdata;
		end

		nxt_cksum = cksum_ff;
		if (reg_wr) begin
			if (on_status_page && (reg_addr == `DSSR_ADDR_CKSUM)) begin
				nxt_cksum = reg_wdata;
			end else begin
				nxt_cksum = cksum_step(cksum_ff, reg_wdata);
			end
		end

		// read mux; offset zero reads page select on any page, else unmapped or other page reads zero
		nxt_rdata = `DSSR_RST_ZERO;
		if (reg_addr == `DSSR_ADDR_PAGE_SEL) begin
			nxt_rdata = page_ff;
		end else if (on_status_page) begin
			unique case (reg_addr)
				`DSSR_ADDR_CHAN_PWR: nxt_rdata = chan_pwr_ff;
				`DSSR_ADDR_DEV_STATE: nxt_rdata = {dev_state_ff[7:1], recov_ff};
				`DSSR_ADDR_CKSUM: nxt_rdata = cksum_ff;
				default: nxt_rdata = `DSSR_RST_ZERO;
			endcase
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_ff <= `DSSR_RST_SYNC;
			sync2_ff <= `DSSR_RST_SYNC;
			chan_pwr_ff <= `DSSR_RST_ZERO;
			dev_state_ff <= `DSSR_RST_DEV_STATE;
			cksum_ff <= `DSSR_RST_CKSUM;
			page_ff <= `DSSR_RST_PAGE;
			rdata_ff <= `DSSR_RST_ZERO;
			recov_ff <= 1'b0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			chan_pwr_ff <= nxt_chan_pwr;
			dev_state_ff <= nxt_dev_state;
			cksum_ff <= nxt_cksum;
			page_ff <= nxt_page;
			rdata_ff <= nxt_rdata;
			recov_ff <= nxt_recov;
		end
	end

	assign reg_rdata = rdata_ff;
	assign page_sel = page_ff;
	assign manual_recovery_trigger = recov_ff;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking dssr_cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Images are registered, so checks look one edge back at the synchronised levels

	ch_one_live_a: assert property (chan_pwr_ff[7] == $past(sync2_ff[0]))
		else $error("channel one power bit stale");
	ch_two_live_a: assert property (chan_pwr_ff[6] == $past(sync2_ff[1]))
		else $error("channel two power bit stale");
	mode_state_a: assert property ($past(sync2_ff[2]) |-> dev_state_ff[7:6] == 2'b11)
		else $error("active mode code wrong");
	mode_sleep_a: assert property (!$past(sync2_ff[2]) |-> dev_state_ff[7:5] == 3'b100)
		else $error("sleep mode code wrong");
	mode_run_a: assert property ($past(sync2_ff[2]) && ($past(sync2_ff[0]) || $past(sync2_ff[1]))
		|-> dev_state_ff[7:5] == 3'b111)
		else $error("run mode code wrong");
	mode_idle_a: assert property ($past(sync2_ff[2]) && !$past(sync2_ff[0]) && !$past(sync2_ff[1])
		|-> dev_state_ff[7:5] == 3'b110)
		else $error("idle mode code wrong");
	boost_bias_a: assert property (dev_state_ff[4:3] == {$past(sync2_ff[3]), $past(sync2_ff[4])})
		else $error("boost or bias bit stale");
	fault_flags_a: assert property (dev_state_ff[2:1] == {|$past(sync2_ff[6:5]), &$past(sync2_ff[8:7])})
		else $error("fault shutdown flags wrong");
	recov_pulse_a: assert property (reg_wr && page_ff == 8'h00 && reg_addr == 8'h77 && reg_wdata[0]
		|=> recov_ff)
		else $error("recovery pulse missing");
	recov_clear_a: assert property (recov_ff |-> $past(reg_wr) && $past(page_ff) == 8'h00
		&& $past(reg_addr) == 8'h77 && $past(reg_wdata[0]))
		else $error("recovery pulse without a write");
	cksum_load_a: assert property (reg_wr && page_ff == 8'h00 && reg_addr == 8'h7E
		|=> cksum_ff == $past(reg_wdata))
		else $error("checksum not overwritten");
	cksum_step_a: assert property (reg_wr && !(page_ff == 8'h00 && reg_addr == 8'h7E)
		|=> cksum_ff == cksum_step($past(cksum_ff), $past(reg_wdata)))
		else $error("checksum not stepped on write");
	cksum_hold_a: assert property (!reg_wr |=> cksum_ff == $past(cksum_ff))
		else $error("checksum changed without write");
	reserved_zero_a: assert property (reg_addr == 8'h76 && page_ff == 8'h00 |=> reg_rdata[5:0] == 6'h0)
		else $error("reserved bits not zero");
	page_sel_a: assert property (reg_wr && reg_addr == 8'h00 |=> page_sel == $past(reg_wdata))
		else $error("page select not taken");
	rdata_page_a: assert property (reg_addr == 8'h00 |=> reg_rdata == $past(page_ff))
		else $error("page select readback wrong");

endmodule : dssr_status_regs

`default_nettype wire

// File: hw/dssr_defines.svh
// Offsets, field positions and reset values of the device status and checksum registers.
// Assumes an 8-bit register address and data path on page-organised register space.
`ifndef DSSR_DEFINES_SVH
`define DSSR_DEFINES_SVH

// Register offsets within a page
`define DSSR_ADDR_PAGE_SEL 8'h00
`define DSSR_ADDR_CHAN_PWR 8'h76
`define DSSR_ADDR_DEV_STATE 8'h77
`define DSSR_ADDR_CKSUM 8'h7E

// Page that holds the status and checksum registers
`define DSSR_PAGE_STATUS 8'h00

// Reset values
`define DSSR_RST_PAGE 8'h00
`define DSSR_RST_DEV_STATE 8'h80
`define DSSR_RST_CKSUM 8'h00
`define DSSR_RST_ZERO 8'h00
`define DSSR_RST_SYNC 9'h000

// Field positions, first status register
`define DSSR_BIT_CH1_UP 7
`define DSSR_BIT_CH2_UP 6

// Field positions, second status register
`define DSSR_FLD_MODE_HI 7
`define DSSR_FLD_MODE_LO 5
`define DSSR_BIT_BOOST 4
`define DSSR_BIT_BIAS 3
`define DSSR_BIT_IN_FLT 2
`define DSSR_BIT_BIAS_FLT 1
`define DSSR_BIT_RECOVER 0

// Width of the synchronised status input vector
`define DSSR_SYNC_W 9

`endif

// File: hw/dssr_pkg.sv
// Types shared by the device status and checksum register block.
// Assumes the constants header is included by any user of the offsets.
`default_nettype none
package dssr_pkg;

	// Device state field codes
	typedef enum logic [2:0] {
		DSSR_MODE_SLEEP = 3'b100,
		DSSR_MODE_IDLE = 3'b110,
		DSSR_MODE_RUN = 3'b111
	} dssr_mode_t;

	// One register byte
	typedef logic [7:0] dssr_byte_t;

endpackage : dssr_pkg
`default_nettype wire

// File: bench/dssr_host_model.sv
// Host controller model: byte writes and reads on the register bus.
// Assumes the device samples on the rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module dssr_host_model (
	input wire logic clk, // Register clock
	input wire logic [7:0] reg_rdata, // Read data
	output var logic reg_wr, // Write strobe
	output var logic [7:0] reg_addr, // Offset
	output var logic [7:0] reg_wdata // Write data
);
	// ==========
	// Bus tasks
	// Signals move on falling edges so each rising edge sees them settled
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// host discipline
	// Unmapped offsets are used too (0x16, 0x10); the fault setup is never touched
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	// Data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
endmodule : dssr_host_model
`default_nettype wire

// File: bench/device_status_checksum_regs_tb.sv
// Bench for the status and checksum registers.
// Assumes the host model drives the bus; status inputs move on falling edges.
`timescale 1ns/10ps
`default_nettype none
module device_status_checksum_regs_tb;
	import dssr_pkg::*;
	logic clk, nrst, reg_wr, trig;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, page_sel, v;
	logic [7:0] ck = 8'h00; // Expected checksum
	logic [7:0] pg = 8'h00; // Expected page
	logic [8:0] st = 9'h000; // ch1 ch2 act boost bias infault[2] biasfault[2]
	logic [8:0] tbl [7] = '{9'h000, 9'h1FF, 9'h140, 9'h0E0, 9'h049, 9'h053, 9'h1A0};
	int err_count = 0;
	int comparisons = 0;
	dssr_status_regs uut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .chan_one_powered(st[8]), .chan_two_powered(st[7]),
		.device_active(st[6]), .boost_powered(st[5]), .mic_bias_powered(st[4]),
		.chan_input_fault_pd(st[3:2]), .chan_bias_fault_pd(st[1:0]), .reg_rdata(reg_rdata),
		.page_sel(page_sel), .manual_recovery_trigger(trig));
	dssr_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	// ==========
	// Helpers
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Write and track checksum; page 0 0x7E overwrites, all else steps
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		ck = (pg == 8'h00 && a == 8'h7E) ? d : {ck[6:0], ck[7]} + d;
		if (a == 8'h00) pg = d;
	endtask : w
	function automatic logic [7:0] e77(input logic [8:0] s);
		logic [2:0] m;
		m = !s[6] ? 3'b100 : ((s[8] | s[7]) ? 3'b111 : 3'b110);
		return {m, s[5], s[4], |s[3:2], &s[1:0], 1'b0};
	endfunction : e77
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	// ==========
	// Scenarios
	task automatic t_reset;
		host.rd(8'h77, v); chk(v, 8'h80);
		host.rd(8'h76, v); chk(v, 8'h00);
		host.rd(8'h7E, v); chk(v, 8'h00);
		chk(page_sel, 8'h00);
		$display("reset test done");
	endtask : t_reset
	// Sweep status levels; synchronisers need several edges
	task automatic t_status;
		for (int i = 0; i < 7; i++) begin
			@(negedge clk);
			st = tbl[i];
			repeat (5) @(negedge clk);
			host.rd(8'h76, v); chk(v, {st[8], st[7], 6'h00});
			host.rd(8'h77, v); chk(v, e77(st));
		end
		$display("status test done");
	endtask : t_status
	task automatic t_cksum;
		w(8'h7E, 8'hA5);
		host.rd(8'h7E, v); chk(v, 8'hA5);
		w(8'h76, 8'h00);
		host.rd(8'h76, v); chk(v, {st[8], st[7], 6'h00});
		host.rd(8'h7E, v); chk(v, ck);
		$display("checksum test done");
	endtask : t_cksum
	// Recovery pulse lasts one cycle; upper bits ignore writes
	task automatic t_recover;
		w(8'h77, 8'hFF);
		chk({7'h00, trig}, 8'h01);
		@(negedge clk);
		chk({7'h00, trig}, 8'h00);
		host.rd(8'h77, v); chk(v, e77(st));
		host.rd(8'h7E, v); chk(v, ck);
		$display("recovery test done");
	endtask : t_recover
	task automatic t_page;
		w(8'h00, 8'h01);
		chk(page_sel, 8'h01);
		host.rd(8'h7E, v); chk(v, 8'h00);
		w(8'h16, 8'h5A);
		w(8'h00, 8'h00);
		host.rd(8'h7E, v); chk(v, ck);
		host.rd(8'h10, v); chk(v, 8'h00);
		$display("page test done");
	endtask : t_page
	// Mid-run reset returns checksum, page and status images to reset values
	task automatic t_midreset;
		w(8'h00, 8'h02);
		@(negedge clk);
		st = 9'h000;
		nrst = 1'b0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		ck = 8'h00;
		pg = 8'h00;
		t_reset();
	endtask : t_midreset
	// ==========
	// Main sequence and hang guard
	initial begin
		nrst = 1'b0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		t_reset();
		t_status();
		t_cksum();
		t_recover();
		t_page();
		t_midreset();
		final_report();
	end
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		final_report();
	end
endmodule : device_status_checksum_regs_tb
`default_nettype wire
